// ---- design/adcc_pkg.sv ----
// Constants shared by the converter control block and its bench.
// Assumes a single 20 MHz core clock and a slower external master clock.
package adcc_pkg;
   localparam int CORE_CLK_HZ = 20_000_000;
   localparam int MCLK_MAX_HZ = 2_500_000;
   localparam int MCLK_MIN_HZ = 100_000;
   localparam int SER_BITS = 16;
   localparam int CTRL_BITS = 5;
   localparam int ADDR_BITS = 3;
   localparam int RESULT_BITS = 12;
   localparam int ADDR_MSB = 4;
   localparam int ADDR_LSB = 2;
   localparam int CTRL_RESET = 0;
   localparam int CAP_BITS = 8;
   localparam int SETTLE_BITS = 16;
   localparam int CONV_TIME_NS = 5900;
   localparam int CONV_MCLK_CYC = CONV_TIME_NS / (1_000_000_000 / MCLK_MAX_HZ);
   localparam int SETTLE_BASE_NS = 1000;
   localparam int SETTLE_UNIT_NS = 100;
   localparam int CORE_NS = 1_000_000_000 / CORE_CLK_HZ;
   localparam int SETTLE_BASE_CYC = (SETTLE_BASE_NS + CORE_NS - 1) / CORE_NS;
   localparam int SETTLE_UNIT_CYC = (SETTLE_UNIT_NS + CORE_NS - 1) / CORE_NS;
   localparam int CONV_CNT_BITS = 5;
   localparam int TX_CNT_BITS = 5;
   localparam int RX_CNT_BITS = 3;
   typedef enum logic [1:0] {ADCC_IDLE, ADCC_WAIT_SETTLE, ADCC_CONVERT} adcc_state_t;
endpackage

// ---- design/adcc_sync.sv ----
// Two-stage synchroniser with edge detection for one pin input.
// Assumes the pin is asynchronous to i_core_clk and changes slower than it.
`timescale 1ns/10ps
module adcc_sync #(
   parameter logic IDLE_LEVEL = 1'b0
) (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_async,
   output logic o_level,
   output logic o_rise,
   output logic o_fall
);
   logic meta_reg;
   logic sync_reg;
   logic last_reg;

   // Only the second stage is looked at, so a metastable first stage never reaches logic.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      // Resetting to the pin's idle level keeps a false edge out of the first cycles.
      if (i_rst) begin
         meta_reg <= IDLE_LEVEL;
         sync_reg <= IDLE_LEVEL;
         last_reg <= IDLE_LEVEL;
      end else begin
         meta_reg <= i_async;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign o_level = sync_reg;
   assign o_rise = sync_reg & ~last_reg;
   assign o_fall = ~sync_reg & last_reg;
endmodule

// ---- design/adcc_ctrl.sv ----
// Conversion start, settling delay and serial port control of the converter.
// Assumes pins arrive asynchronously and the analog core presents i_adc_result.
`timescale 1ns/10ps
module adcc_ctrl (
   input wire logic i_core_clk,
   input wire logic i_rst,
   input wire logic i_master_clk,
   input wire logic i_serial_mode_select,
   input wire logic i_conversion_trigger,
   input wire logic [adcc_pkg::CAP_BITS-1:0] i_settling_timing_capacitor,
   input wire logic [adcc_pkg::RESULT_BITS-1:0] i_adc_result,
   input wire logic i_sclk,
   output logic o_sclk,
   output logic o_sclk_oe,
   input wire logic i_receive_frame_sync_n,
   output logic o_receive_frame_sync_n,
   output logic o_receive_frame_sync_oe,
   input wire logic i_transmit_frame_sync_n,
   input wire logic i_data_in,
   output logic o_data_out,
   output logic o_data_out_oe,
   output logic o_hold,
   output logic [adcc_pkg::CTRL_BITS-1:0] o_control
);
   logic mclk_lvl, mclk_rise, mclk_fall;
   logic serial_mode_select_lvl, trig_lvl, trig_rise;
   logic sclk_lvl, sclk_in_rise, sclk_in_fall;
   logic rfs_lvl, rfs_in_fall;
   logic tfs_lvl, tfs_fall;
   logic din_lvl;
   logic master_reg, sclk_reg, frame_reg, dout_reg, dout_oe_reg, hold_reg;
   logic [adcc_pkg::CTRL_BITS-1:0] ctrl_reg;
   logic [adcc_pkg::RX_CNT_BITS-1:0] rx_cnt_reg;
   logic [adcc_pkg::TX_CNT_BITS-1:0] tx_cnt_reg;
   logic [adcc_pkg::SER_BITS-1:0] shift_reg, out_word_reg;
   logic [adcc_pkg::SETTLE_BITS-1:0] settle_cnt_reg;
   logic [adcc_pkg::CONV_CNT_BITS-1:0] conv_cnt_reg;
   adcc_pkg::adcc_state_t state_reg;
   logic settle_active, conv_done, ctrl_load, run_sclk, sc_rise, sc_fall, frame_on;

   function automatic logic [adcc_pkg::SETTLE_BITS-1:0] settle_len(
      input logic [adcc_pkg::CAP_BITS-1:0] cap);
      settle_len = adcc_pkg::SETTLE_BITS'(adcc_pkg::SETTLE_BASE_CYC)
         + adcc_pkg::SETTLE_BITS'(cap) * adcc_pkg::SETTLE_BITS'(adcc_pkg::SETTLE_UNIT_CYC);
   endfunction

   adcc_sync u_mclk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_async(i_master_clk),
      .o_level(mclk_lvl), .o_rise(mclk_rise), .o_fall(mclk_fall));
   adcc_sync u_serial_mode_select (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_async(i_serial_mode_select),
      .o_level(serial_mode_select_lvl), .o_rise(), .o_fall());
   adcc_sync u_trig (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_async(i_conversion_trigger),
      .o_level(trig_lvl), .o_rise(trig_rise), .o_fall());
   adcc_sync u_sclk (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_async(i_sclk),
      .o_level(sclk_lvl), .o_rise(sclk_in_rise), .o_fall(sclk_in_fall));
   adcc_sync #(.IDLE_LEVEL(1'b1)) u_rfs (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_async(i_receive_frame_sync_n), .o_level(rfs_lvl), .o_rise(), .o_fall(rfs_in_fall));
   adcc_sync #(.IDLE_LEVEL(1'b1)) u_tfs (.i_core_clk(i_core_clk), .i_rst(i_rst),
      .i_async(i_transmit_frame_sync_n), .o_level(tfs_lvl), .o_rise(), .o_fall(tfs_fall));
   adcc_sync u_din (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_async(i_data_in),
      .o_level(din_lvl), .o_rise(), .o_fall());

   assign settle_active = settle_cnt_reg != '0;
   assign conv_done = state_reg == adcc_pkg::ADCC_CONVERT && mclk_rise
      && conv_cnt_reg == adcc_pkg::CONV_CNT_BITS'(adcc_pkg::CONV_MCLK_CYC - 1);
   assign ctrl_load = sc_fall && !tfs_lvl
      && rx_cnt_reg == adcc_pkg::RX_CNT_BITS'(adcc_pkg::CTRL_BITS - 1);
   // The master clock is passed only while something is framed, so the pin idles low.
   assign run_sclk = frame_reg || !tfs_lvl;
   assign sc_rise = master_reg ? (mclk_rise && run_sclk && !sclk_reg) : sclk_in_rise;
   assign sc_fall = master_reg ? (mclk_fall && sclk_reg) : sclk_in_fall;
   assign frame_on = master_reg ? frame_reg : !rfs_lvl;

   // Mode is sampled continuously; it is expected to stay put while busy.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         master_reg <= 1'b0;
      end else begin
         master_reg <= !serial_mode_select_lvl;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         settle_cnt_reg <= '0;
      end else if (ctrl_load) begin
         settle_cnt_reg <= settle_len(i_settling_timing_capacitor);
      end else if (settle_active) begin
         settle_cnt_reg <= settle_cnt_reg - 1'b1;
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= adcc_pkg::ADCC_IDLE;
         hold_reg <= 1'b0;
         conv_cnt_reg <= '0;
         out_word_reg <= '0;
      end else begin
         unique case (state_reg)
            adcc_pkg::ADCC_IDLE: begin
               if (trig_rise && settle_active) begin
                  state_reg <= adcc_pkg::ADCC_WAIT_SETTLE;
               end else if (trig_rise) begin
                  state_reg <= adcc_pkg::ADCC_CONVERT;
                  hold_reg <= 1'b1;
                  conv_cnt_reg <= '0;
               end
            end
            adcc_pkg::ADCC_WAIT_SETTLE: begin
               if (!settle_active) begin
                  state_reg <= adcc_pkg::ADCC_CONVERT;
                  hold_reg <= 1'b1;
                  conv_cnt_reg <= '0;
               end
            end
            adcc_pkg::ADCC_CONVERT: begin
               if (conv_done) begin
                  state_reg <= adcc_pkg::ADCC_IDLE;
                  hold_reg <= 1'b0;
                  out_word_reg <= {1'b0, ctrl_reg[adcc_pkg::ADDR_MSB:adcc_pkg::ADDR_LSB],
                     i_adc_result};
               end else if (mclk_rise) begin
                  conv_cnt_reg <= conv_cnt_reg + 1'b1;
               end
            end
         endcase
      end
   end

   // Control bits enter MSB first on falling shift clock edges.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         rx_cnt_reg <= '0;
         ctrl_reg <= adcc_pkg::CTRL_BITS'(adcc_pkg::CTRL_RESET);
      end else if (tfs_fall) begin
         rx_cnt_reg <= '0;
      end else if (sc_fall && !tfs_lvl
            && rx_cnt_reg < adcc_pkg::RX_CNT_BITS'(adcc_pkg::CTRL_BITS)) begin
         rx_cnt_reg <= rx_cnt_reg + 1'b1;
         ctrl_reg <= {ctrl_reg[adcc_pkg::CTRL_BITS-2:0], din_lvl};
      end
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         sclk_reg <= 1'b0;
      end else if (!master_reg) begin
         sclk_reg <= 1'b0;
      end else if (sc_rise) begin
         sclk_reg <= 1'b1;
      end else if (sc_fall) begin
         sclk_reg <= 1'b0;
      end
   end

   // The first rising edge of a frame comes before the first sampling edge, so no shift then.
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         frame_reg <= 1'b0;
         tx_cnt_reg <= '0;
         shift_reg <= '0;
         dout_reg <= 1'b0;
         dout_oe_reg <= 1'b0;
      end else if ((master_reg && conv_done && !frame_reg) || (!master_reg && rfs_in_fall)) begin
         frame_reg <= master_reg;
         tx_cnt_reg <= '0;
         shift_reg <= master_reg ? {1'b0, ctrl_reg[adcc_pkg::ADDR_MSB:adcc_pkg::ADDR_LSB],
            i_adc_result} : out_word_reg;
         dout_reg <= 1'b0;
         dout_oe_reg <= 1'b1;
      end else if (!frame_on) begin
         frame_reg <= 1'b0;
         dout_oe_reg <= 1'b0;
      end else if (sc_fall && tx_cnt_reg < adcc_pkg::TX_CNT_BITS'(adcc_pkg::SER_BITS)) begin
         tx_cnt_reg <= tx_cnt_reg + 1'b1;
         if (tx_cnt_reg == adcc_pkg::TX_CNT_BITS'(adcc_pkg::SER_BITS - 1)) begin
            frame_reg <= 1'b0;
            // A master keeps the line one more cycle, so the bit still stands at the last fall.
            dout_oe_reg <= master_reg;
         end
      end else if (sc_rise && tx_cnt_reg != '0) begin
         shift_reg <= {shift_reg[adcc_pkg::SER_BITS-2:0], 1'b0};
         dout_reg <= shift_reg[adcc_pkg::SER_BITS-2];
      end
   end

   assign o_sclk = sclk_reg;
   assign o_sclk_oe = master_reg;
   assign o_receive_frame_sync_n = !frame_reg;
   assign o_receive_frame_sync_oe = master_reg;
   assign o_data_out = dout_reg;
   assign o_data_out_oe = dout_oe_reg;
   assign o_hold = hold_reg;
   assign o_control = ctrl_reg;

   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_rst);

   chk_master_drives: assert property (!serial_mode_select_lvl |=> o_sclk_oe && o_receive_frame_sync_oe)
      else $error("master mode does not drive clock and sync");
   chk_slave_released: assert property (serial_mode_select_lvl |=> !o_sclk_oe && !o_receive_frame_sync_oe)
      else $error("slave mode still drives clock or sync");
   chk_trigger_holds: assert property (state_reg == adcc_pkg::ADCC_IDLE && trig_rise
      && !settle_active |=> o_hold)
      else $error("trigger did not start hold");
   chk_settle_defers: assert property (state_reg == adcc_pkg::ADCC_IDLE && trig_rise
      && settle_active |=> !o_hold [*2])
      else $error("hold began during settling pulse");
   chk_settle_length: assert property (ctrl_load |=>
      settle_cnt_reg == settle_len($past(i_settling_timing_capacitor)))
      else $error("settling pulse length wrong");
   chk_conv_length: assert property ($fell(o_hold) |->
      $past(conv_cnt_reg) == adcc_pkg::CONV_CNT_BITS'(adcc_pkg::CONV_MCLK_CYC - 1))
      else $error("conversion ended at wrong master clock count");
   chk_sclk_follows: assert property (master_reg && run_sclk && mclk_rise && !sclk_reg
      |=> o_sclk)
      else $error("shift clock did not follow master clock");
   chk_frame_bits: assert property ($rose(o_receive_frame_sync_n) && master_reg |->
      $past(tx_cnt_reg) == adcc_pkg::TX_CNT_BITS'(adcc_pkg::SER_BITS - 1))
      else $error("read frame length not sixteen");
   chk_ctrl_limit: assert property (rx_cnt_reg == adcc_pkg::RX_CNT_BITS'(adcc_pkg::CTRL_BITS)
      && !tfs_fall |=> $stable(ctrl_reg))
      else $error("control register changed after five bits");
   chk_shift_in: assert property (sc_fall && !tfs_lvl && !tfs_fall
      && rx_cnt_reg < adcc_pkg::RX_CNT_BITS'(adcc_pkg::CTRL_BITS)
      |=> rx_cnt_reg == $past(rx_cnt_reg) + 1'b1)
      else $error("shift clock edge lost on input");

   cov_deferred: cover property (state_reg == adcc_pkg::ADCC_WAIT_SETTLE ##1 o_hold);
   cov_master_frame: cover property (master_reg && $fell(o_receive_frame_sync_n));
   cov_slave_frame: cover property (!master_reg && rfs_in_fall);
   cov_ctrl_loaded: cover property (ctrl_load);
endmodule

// ---- bench/adcc_host_model.sv ----
// Behavioural serial port of the controller that faces the converter's pins.
// Assumes the bench resolves the shared lines and feeds the wire levels back in.
`timescale 1ns/10ps
module adcc_host_model (
   input wire logic i_slave,
   input wire logic i_sclk_wire,
   input wire logic i_data_wire,
   output logic o_sclk,
   output logic o_receive_frame_sync_n,
   output logic o_transmit_frame_sync_n,
   output logic o_data
);
   logic timed_out = 1'b0;
   initial begin
      o_sclk = 1'b0;
      o_receive_frame_sync_n = 1'b1;
      o_transmit_frame_sync_n = 1'b1;
      o_data = 1'b0;
   end
   task automatic wait_sclk(input logic lvl);
      int n;
      n = 0;
      // Polling in 10 ns steps keeps every change of the host off the core clock edges.
      while (i_sclk_wire !== lvl && n < 1000) begin
         #10;
         n++;
      end
      if (n >= 1000) timed_out = 1'b1;
   endtask
   // Data moves on rising shift edges and is taken on falling ones, so it never races a fall.
   task automatic shift(input int nbits, input logic [15:0] tx, output logic [15:0] rx);
      rx = 16'h0000;
      for (int i = 0; i < nbits; i++) begin
         if (i_slave) begin
            o_sclk = 1'b1;
            o_data = tx[15-i];
            #200;
         end else begin
            wait_sclk(1'b1);
            o_data = tx[15-i];
            wait_sclk(1'b0);
         end
         rx = {rx[14:0], i_data_wire};
         if (i_slave) begin
            o_sclk = 1'b0;
            #200;
         end
      end
   endtask
   task automatic write_ctrl(input int nbits, input logic [15:0] tx);
      logic [15:0] rx;
      o_data = tx[15];
      o_transmit_frame_sync_n = 1'b0;
      if (i_slave) #200;
      shift(nbits, tx, rx);
      #200;
      o_transmit_frame_sync_n = 1'b1;
   endtask
   task automatic read_frame(output logic [15:0] rx);
      if (i_slave) begin
         o_receive_frame_sync_n = 1'b0;
         #200;
      end
      shift(16, 16'h0000, rx);
      #200;
      o_receive_frame_sync_n = 1'b1;
   endtask
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the converter control block with a serial host model.
// Assumes a free-running 2.5 MHz master clock and a 20 MHz core clock.
`timescale 1ns/10ps
module tb_top;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic mclk = 1'b0;
   logic mode = 1'b0;
   logic trig = 1'b0;
   logic [adcc_pkg::CAP_BITS-1:0] cap = 8'h00;
   logic [adcc_pkg::RESULT_BITS-1:0] result = 12'h000;
   logic o_sclk, o_sclk_oe, o_rfs_n, o_rfs_oe, o_dout, o_dout_oe, o_hold;
   logic [adcc_pkg::CTRL_BITS-1:0] o_control;
   logic h_sclk, h_rfs_n, h_tfs_n, h_data;
   logic data_last = 1'b0;
   logic [15:0] rx;
   int fail_count = 0;
   int n_checks = 0;
   int c;
   wire logic sclk_w = o_sclk_oe ? o_sclk : h_sclk;
   wire logic rfs_w = o_rfs_oe ? o_rfs_n : h_rfs_n;
   // A released data line shows the inverse of its last value, never a lucky match.
   wire logic data_w = o_dout_oe ? o_dout : ~data_last;
   initial forever #25 i_core_clk = ~i_core_clk;
   initial forever #200 mclk = ~mclk;
   always_ff @(posedge i_core_clk) if (o_dout_oe) data_last <= o_dout;
   adcc_ctrl dut (.i_core_clk(i_core_clk), .i_rst(i_rst), .i_master_clk(mclk),
      .i_serial_mode_select(mode), .i_conversion_trigger(trig),
      .i_settling_timing_capacitor(cap), .i_adc_result(result), .i_sclk(sclk_w),
      .o_sclk(o_sclk), .o_sclk_oe(o_sclk_oe), .i_receive_frame_sync_n(rfs_w),
      .o_receive_frame_sync_n(o_rfs_n), .o_receive_frame_sync_oe(o_rfs_oe),
      .i_transmit_frame_sync_n(h_tfs_n), .i_data_in(h_data), .o_data_out(o_dout),
      .o_data_out_oe(o_dout_oe), .o_hold(o_hold), .o_control(o_control));
   adcc_host_model host (.i_slave(mode), .i_sclk_wire(sclk_w), .i_data_wire(data_w),
      .o_sclk(h_sclk), .o_receive_frame_sync_n(h_rfs_n),
      .o_transmit_frame_sync_n(h_tfs_n), .o_data(h_data));
   task automatic wrap_up();
      if (fail_count == 0 && n_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
      n_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("CHECK FAILED %0t %s: saw %h expected %h", $time, msg, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge i_core_clk);
      #5;
   endtask
   task automatic wait_hold(input logic lvl, input int lim, output int cyc);
      cyc = 0;
      while (o_hold !== lvl && cyc < lim) begin
         step(1);
         cyc++;
      end
      if (o_hold !== lvl) begin
         fail_count++;
         $display("CHECK FAILED %0t hold wait ran out", $time);
         wrap_up();
      end
   endtask
   // One conversion from trigger to a read frame; the trigger rises lead cycles after the call starts.
   task automatic convert(input int lead, input int early, input logic [11:0] res,
      input logic [2:0] addr);
      result = res;
      step(lead);
      trig = 1'b1;
      if (early > 0) begin
         step(early);
         chk(16'(o_hold), 16'h0000, "hold during settling");
      end
      wait_hold(1'b1, early > 0 ? 120 : 8, c);
      trig = 1'b0;
      wait_hold(1'b0, 130, c);
      chk(16'(c >= 100 && c <= 118), 16'h0001, "hold length");
      if (!mode) begin
         step(1);
         chk(16'(o_rfs_n), 16'h0000, "master read sync");
      end
      host.read_frame(rx);
      chk(rx, {1'b0, addr, res}, "read word");
      chk(16'(o_dout_oe), 16'h0000, "data line released");
      step(20);
   endtask
   task automatic t_master();
      chk(16'({o_sclk_oe, o_rfs_oe}), 16'h0003, "master drives");
      host.write_ctrl(5, 16'hb000);
      step(4);
      chk(16'(o_control), 16'h0016, "control master");
      convert(40, 0, 12'ha5c, 3'b101);
   endtask
   task automatic t_settle();
      cap = 8'h64;
      host.write_ctrl(5, 16'h4000);
      convert(20, 150, 12'h7e3, 3'b010);
      cap = 8'h00;
   endtask
   task automatic t_slave();
      mode = 1'b1;
      step(8);
      chk(16'({o_sclk_oe, o_rfs_oe}), 16'h0000, "slave releases");
      host.write_ctrl(7, 16'h6e00);
      step(4);
      chk(16'(o_control), 16'h000d, "control slave");
      convert(40, 0, 12'h3c1, 3'b011);
   endtask
   initial begin
      step(16);
      i_rst = 1'b0;
      step(8);
      t_master();
      t_settle();
      t_slave();
      chk(16'(host.timed_out), 16'h0000, "host shift clock waits");
      wrap_up();
   end
endmodule
